// ---- dmem_core_model.sv ----
// Core side model issuing data memory accesses
`timescale 1ns/100ps
`default_nettype none
module dmem_core_model
	import dmem_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Request out, answer in
	output var req_s req,
	input wire resp_s resp_q
);
	initial req = '0;
	// One access; answer taken a cycle later
	task automatic acc(input op_e op, input logic ext, input addr_t a, input logic [7:0] wd,
		output logic [7:0] d, output addr_t ea);
		req = {1'b1, op, ext, a, wd};
		@(negedge clk_sys);
		d = resp_q.data;
		ea = resp_q.eff_addr;
	endtask
	// Released lines show stale inverted values
	task automatic idle();
		req = {1'b0, ~req[19:0]};
	endtask
endmodule
`default_nettype wire

// ---- dmem_indirect.sv ----
// Data memory with indirect ports, pointers and sector-extended direct addressing
`timescale 1ns/100ps
`default_nettype none
module dmem_indirect
	import dmem_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Core request
	input wire req_s req,
	// Core answer
	output resp_s resp_q
);

	// Sector selected by a pointer high byte
	function automatic sector_t sector_of(input logic [7:0] hi);
		sector_of = hi[SECTOR_BITS-1:0];
	endfunction

	// Offset is one of the three indirect ports in sector 0
	function automatic logic is_port(input addr_t a);
		logic [7:0] o;
		o = a[7:0];
		is_port = (a[ADDR_BITS-1:8] == SECTOR_ZERO) &&
			((o == OFS_INDIRECT_PORT_A) || (o == OFS_INDIRECT_PORT_B) ||
			(o == OFS_INDIRECT_PORT_C));
	endfunction

	// Kind of storage behind a resolved address
	function automatic tgt_e target_of(input addr_t a);
		logic [7:0] o;
		o = a[7:0];
		target_of = TGT_NONE;
		if (o >= RAM_BASE) begin
			target_of = TGT_RAM;
		end else if (a[ADDR_BITS-1:8] == SECTOR_ZERO) begin
			case (o)
				OFS_POINTER_A, OFS_POINTER_B_LOW, OFS_POINTER_B_SECTOR,
				OFS_POINTER_C_LOW, OFS_POINTER_C_SECTOR: target_of = TGT_PTR;
				default: target_of = TGT_NONE;
			endcase
		end
	endfunction

	// Full address from a pointer pair: high byte sector, low byte offset
	function automatic addr_t pair_addr(input logic [7:0] hi, input logic [7:0] lo);
		pair_addr = {sector_of(hi), lo};
	endfunction

	// One-hot select of the pointer register at a sector 0 offset
	function automatic logic [4:0] ptr_select(input logic [7:0] o);
		ptr_select = 5'h00;
		case (o)
			OFS_POINTER_A: ptr_select = 5'h01;
			OFS_POINTER_B_LOW: ptr_select = 5'h02;
			OFS_POINTER_B_SECTOR: ptr_select = 5'h04;
			OFS_POINTER_C_LOW: ptr_select = 5'h08;
			OFS_POINTER_C_SECTOR: ptr_select = 5'h10;
			default: ptr_select = 5'h00;
		endcase
	endfunction

	logic [7:0] mem [0:MEM_WORDS-1];
	logic [7:0] pointer_a_q;
	logic [7:0] pointer_b_low_q;
	logic [7:0] pointer_b_sector_q;
	logic [7:0] pointer_c_low_q;
	logic [7:0] pointer_c_sector_q;

	addr_t raw_addr;
	addr_t eff_addr;
	logic indirect;
	tgt_e tgt;
	logic [7:0] ptr_val;
	logic [7:0] old_val;
	logic [7:0] new_val;
	logic do_write;
	logic ram_we;
	logic [4:0] ptr_we;
	logic port_loop;
	addr_t port_a_addr;
	addr_t port_b_addr;
	addr_t port_c_addr;
	logic ans_valid_q;
	logic [7:0] ans_data_q;
	addr_t ans_addr_q;
	logic ans_indirect_q;
	resp_s resp_d;

	// Short direct form reaches sector 0; extended form carries the sector
	always_comb begin
		if (req.ext) begin
			raw_addr = req.addr;
		end else begin
			raw_addr = {SECTOR_ZERO, req.addr[7:0]};
		end
	end

	// Where each port points
	always_comb begin
		port_a_addr = {SECTOR_ZERO, pointer_a_q};
		port_b_addr = pair_addr(pointer_b_sector_q, pointer_b_low_q);
		port_c_addr = pair_addr(pointer_c_sector_q, pointer_c_low_q);
	end

	// Redirect port accesses through their pointers
	always_comb begin
		eff_addr = raw_addr;
		indirect = 1'b0;
		if (raw_addr[ADDR_BITS-1:8] == SECTOR_ZERO) begin
			case (raw_addr[7:0])
				OFS_INDIRECT_PORT_A: begin
					eff_addr = port_a_addr;
					indirect = 1'b1;
				end
				OFS_INDIRECT_PORT_B: begin
					eff_addr = port_b_addr;
					indirect = 1'b1;
				end
				OFS_INDIRECT_PORT_C: begin
					eff_addr = port_c_addr;
					indirect = 1'b1;
				end
				default: begin
					eff_addr = raw_addr;
					indirect = 1'b0;
				end
			endcase
		end
	end

	// A pointer naming a port again has no storage behind it
	always_comb begin
		port_loop = is_port(eff_addr);
	end

	// Kind of storage at the resolved address
	always_comb begin
		if (port_loop) begin
			tgt = TGT_NONE;
		end else begin
			tgt = target_of(eff_addr);
		end
	end

	// Pointer read mux
	always_comb begin
		case (ptr_select(eff_addr[7:0]))
			5'h01: ptr_val = pointer_a_q;
			5'h02: ptr_val = pointer_b_low_q;
			5'h04: ptr_val = pointer_b_sector_q;
			5'h08: ptr_val = pointer_c_low_q;
			5'h10: ptr_val = pointer_c_sector_q;
			default: ptr_val = READ_ZERO;
		endcase
	end

	// Current value at the resolved address
	always_comb begin
		case (tgt)
			TGT_RAM: old_val = mem[eff_addr];
			TGT_PTR: old_val = ptr_val;
			default: old_val = READ_ZERO;
		endcase
	end

	// Value to store back
	always_comb begin
		case (req.op)
			OP_WRITE: new_val = req.wdata;
			OP_INC: new_val = old_val + STEP_ONE;
			OP_DEC: new_val = old_val - STEP_ONE;
			default: new_val = old_val;
		endcase
	end

	// Only real storage is ever written
	always_comb begin
		do_write = req.valid && (req.op != OP_READ) && (tgt != TGT_NONE);
	end

	// RAM write strobe
	assign ram_we = do_write && (tgt == TGT_RAM);

	// Write strobe for each pointer register
	always_comb begin
		ptr_we = 5'h00;
		if (do_write && (tgt == TGT_PTR)) begin
			ptr_we = ptr_select(eff_addr[7:0]);
		end
	end

	// General RAM storage
	always_ff @(posedge clk_sys) begin
		if (ram_we) begin
			mem[eff_addr] <= new_val;
		end
	end

	// Pointer A
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pointer_a_q <= POINTER_RESET;
		end else if (ptr_we[0]) begin
			pointer_a_q <= new_val;
		end
	end

	// Pointer B low byte; wraps alone, no carry into the sector byte
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pointer_b_low_q <= POINTER_RESET;
		end else if (ptr_we[1]) begin
			pointer_b_low_q <= new_val;
		end
	end

	// Pointer B sector byte
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pointer_b_sector_q <= POINTER_RESET;
		end else if (ptr_we[2]) begin
			pointer_b_sector_q <= new_val;
		end
	end

	// Pointer C low byte; wraps alone, no carry into the sector byte
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pointer_c_low_q <= POINTER_RESET;
		end else if (ptr_we[3]) begin
			pointer_c_low_q <= new_val;
		end
	end

	// Pointer C sector byte
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pointer_c_sector_q <= POINTER_RESET;
		end else if (ptr_we[4]) begin
			pointer_c_sector_q <= new_val;
		end
	end

	// Answer: read value, or result of increment and decrement
	always_comb begin
		resp_d.valid = req.valid;
		resp_d.eff_addr = eff_addr;
		resp_d.indirect = indirect;
		if (req.op == OP_WRITE) begin
			resp_d.data = READ_ZERO;
		end else begin
			resp_d.data = new_val;
		end
	end

	// Answer valid, one cycle per request
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ans_valid_q <= 1'b0;
		end else begin
			ans_valid_q <= resp_d.valid;
		end
	end

	// Answer data
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ans_data_q <= READ_ZERO;
		end else begin
			ans_data_q <= resp_d.data;
		end
	end

	// Answer resolved address
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ans_addr_q <= '0;
		end else begin
			ans_addr_q <= resp_d.eff_addr;
		end
	end

	// Answer port flag
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ans_indirect_q <= 1'b0;
		end else begin
			ans_indirect_q <= resp_d.indirect;
		end
	end

	// Answer bundle, straight from the registers
	assign resp_q = {ans_valid_q, ans_data_q, ans_addr_q, ans_indirect_q};

endmodule
`default_nettype wire

// ---- dmem_indirect_bench.sv ----
// Self-checking bench for the indirect data memory block
`timescale 1ns/100ps
`default_nettype none
module dmem_indirect_bench
	import dmem_pkg::*;
;
	logic clk_sys;
	logic nrst = 1'b0;
	req_s req;
	resp_s resp_q;
	int bad_count = 0;
	int samples_checked = 0;
	dmem_indirect dut_u (.clk_sys(clk_sys), .nrst(nrst), .req(req), .resp_q(resp_q));
	dmem_core_model core_u (.clk_sys(clk_sys), .req(req), .resp_q(resp_q));
	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic t(input op_e op, input logic ext, input addr_t a, input logic [7:0] wd,
		input logic [7:0] ed, input addr_t ee);
		logic [7:0] d;
		addr_t ea;
		logic ei;
		ei = (a[7:0] == OFS_INDIRECT_PORT_A || a[7:0] == OFS_INDIRECT_PORT_B ||
			a[7:0] == OFS_INDIRECT_PORT_C) && (!ext || !a[8]);
		core_u.acc(op, ext, a, wd, d, ea);
		check({1'b0, d}, {1'b0, ed});
		check(ea, ee);
		check({7'h00, resp_q.valid, resp_q.indirect}, {7'h00, 1'b1, ei});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#40000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		nrst = 1'b1;
		t(OP_READ, 1'b0, 9'h004, 8'h00, POINTER_RESET, 9'h004);
		t(OP_WRITE, 1'b0, 9'h004, 8'h01, 8'h00, 9'h004);
		t(OP_WRITE, 1'b0, 9'h003, 8'h80, 8'h00, 9'h003);
		t(OP_WRITE, 1'b0, 9'h002, 8'h55, 8'h00, 9'h180);
		t(OP_READ, 1'b1, 9'h180, 8'h00, 8'h55, 9'h180);
		t(OP_WRITE, 1'b1, 9'h1ff, 8'h3c, 8'h00, 9'h1ff);
		t(OP_WRITE, 1'b0, 9'h001, 8'hff, 8'h00, 9'h001);
		t(OP_WRITE, 1'b0, 9'h000, 8'ha5, 8'h00, 9'h0ff);
		t(OP_READ, 1'b1, 9'h0ff, 8'h00, 8'ha5, 9'h0ff);
		t(OP_READ, 1'b0, 9'h001, 8'h00, 8'hff, 9'h001);
		t(OP_INC, 1'b0, 9'h001, 8'h00, 8'h00, 9'h001);
		t(OP_WRITE, 1'b0, 9'h000, 8'h77, 8'h00, 9'h000);
		t(OP_READ, 1'b0, 9'h000, 8'h00, 8'h00, 9'h000);
		t(OP_READ, 1'b1, 9'h100, 8'h00, 8'h00, 9'h100);
		t(OP_WRITE, 1'b0, 9'h003, 8'hff, 8'h00, 9'h003);
		t(OP_INC, 1'b0, 9'h003, 8'h00, 8'h00, 9'h003);
		t(OP_DEC, 1'b0, 9'h003, 8'h00, 8'hff, 9'h003);
		t(OP_READ, 1'b0, 9'h004, 8'h00, 8'h01, 9'h004);
		t(OP_WRITE, 1'b0, 9'h00d, 8'h90, 8'h00, 9'h00d);
		t(OP_WRITE, 1'b0, 9'h00e, 8'h03, 8'h00, 9'h00e);
		t(OP_WRITE, 1'b0, 9'h00c, 8'h66, 8'h00, 9'h190);
		t(OP_READ, 1'b0, 9'h00c, 8'h00, 8'h66, 9'h190);
		core_u.idle();
		@(negedge clk_sys);
		check({8'h00, resp_q.valid}, 9'h000);
		nrst = 1'b0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		t(OP_READ, 1'b0, 9'h003, 8'h00, POINTER_RESET, 9'h003);
		t(OP_READ, 1'b0, 9'h00c, 8'h00, READ_ZERO, 9'h000);
		core_u.idle();
		repeat (2) @(negedge clk_sys);
		close_out();
	end
endmodule
`default_nettype wire

// ---- dmem_indirect_props.sv ----
// Assertion checker for the indirect data memory block
`timescale 1ns/100ps
`default_nettype none
module dmem_indirect_props
	import dmem_pkg::*;
(
	// Clock, reset, core side
	input wire logic clk_sys,
	input wire logic nrst,
	input wire req_s req,
	input wire resp_s resp_q
);
	logic sh;
	logic rd;
	logic [7:0] ofs;
	assign sh = req.valid && !req.ext;
	assign rd = req.valid && req.op == OP_READ;
	assign ofs = req.addr[7:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	AST_RESP_TIMING: assert property (resp_q.valid == $past(req.valid))
		else $error("answer timing wrong");
	AST_PORT_A_SECTOR: assert property (sh && ofs == OFS_INDIRECT_PORT_A |=>
		resp_q.indirect && !resp_q.eff_addr[8]) else $error("port a left sector 0");
	AST_PORT_READ_ZERO: assert property (rd |=>
		!(resp_q.eff_addr inside {9'h000, 9'h002, 9'h00c}) || resp_q.data == READ_ZERO)
		else $error("port location read nonzero");
	AST_UNUSED_ZERO: assert property (rd |=> resp_q.eff_addr[7] || resp_q.data == READ_ZERO ||
		resp_q.eff_addr inside {9'h001, 9'h003, 9'h004, 9'h00d, 9'h00e})
		else $error("unused location read nonzero");
	AST_EXT_ADDR: assert property (req.valid && req.ext && ofs >= RAM_BASE |=>
		resp_q.eff_addr == $past(req.addr) && !resp_q.indirect) else $error("extended address");
	AST_PTR_LOW: assert property (sh && req.op == OP_WRITE && ofs == OFS_POINTER_B_LOW
		##1 sh && ofs == OFS_INDIRECT_PORT_B |=> resp_q.eff_addr[7:0] == $past(req.wdata, 2))
		else $error("port b offset");
	AST_PTR_SECTOR: assert property (sh && req.op == OP_WRITE && ofs == OFS_POINTER_C_SECTOR
		##1 sh && ofs == OFS_INDIRECT_PORT_C |=> resp_q.eff_addr[8] == $past(req.wdata[0], 2))
		else $error("port c sector");
	AST_INC_WRAP: assert property (rd && !req.ext && ofs == OFS_POINTER_A
		##1 sh && req.op == OP_INC && ofs == OFS_POINTER_A
		|=> resp_q.data == 8'($past(resp_q.data) + STEP_ONE)) else $error("increment wrong");
	cover property (sh && ofs == OFS_INDIRECT_PORT_B);
	cover property (req.valid && req.ext && req.addr[8]);
	cover property (sh && req.op == OP_DEC);
endmodule
bind dmem_indirect dmem_indirect_props props_u (.clk_sys(clk_sys), .nrst(nrst), .req(req),
	.resp_q(resp_q));
`default_nettype wire

// ---- dmem_pkg.sv ----
// Constants and types for indirect and sector-extended data memory addressing
package dmem_pkg;

	// Data memory geometry
	localparam int SECTOR_BITS = 1;
	localparam int NUM_SECTORS = 2;
	localparam int ADDR_BITS = SECTOR_BITS + 8;
	localparam int MEM_WORDS = NUM_SECTORS * 256;

	// Special-purpose area ends here; general RAM starts above it
	localparam logic [7:0] SPECIAL_TOP = 8'h7F;
	localparam logic [7:0] RAM_BASE = 8'h80;

	// Register offsets within sector 0
	localparam logic [7:0] OFS_INDIRECT_PORT_A = 8'h00;
	localparam logic [7:0] OFS_POINTER_A = 8'h01;
	localparam logic [7:0] OFS_INDIRECT_PORT_B = 8'h02;
	localparam logic [7:0] OFS_POINTER_B_LOW = 8'h03;
	localparam logic [7:0] OFS_POINTER_B_SECTOR = 8'h04;
	localparam logic [7:0] OFS_INDIRECT_PORT_C = 8'h0C;
	localparam logic [7:0] OFS_POINTER_C_LOW = 8'h0D;
	localparam logic [7:0] OFS_POINTER_C_SECTOR = 8'h0E;

	// Reset, read-as-zero and increment step values
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [7:0] STEP_ONE = 8'h01;
	localparam logic [SECTOR_BITS-1:0] SECTOR_ZERO = '0;

	typedef logic [ADDR_BITS-1:0] addr_t;
	typedef logic [SECTOR_BITS-1:0] sector_t;

	// Access operations issued by the core
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_INC,
		OP_DEC
	} op_e;

	// Kind of location an address resolves to
	typedef enum logic [1:0] {
		TGT_NONE,
		TGT_RAM,
		TGT_PTR
	} tgt_e;

	// Core request: ext selects the extended (all-sector) direct form
	typedef struct packed {
		logic valid;
		op_e op;
		logic ext;
		addr_t addr;
		logic [7:0] wdata;
	} req_s;

	// Answer to the core, one cycle after the request
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		addr_t eff_addr;
		logic indirect;
	} resp_s;

endpackage
